// ---- shared/sfc_pkg.sv ----
package sfc_pkg;
  // Register map, printed offsets on an 8-bit port.
  localparam logic [7:0] SFC_OFS_SYS0  = 8'h05;
  localparam logic [7:0] SFC_OFS_SYS1  = 8'h06;
  localparam logic [7:0] SFC_OFS_APPE  = 8'h07;
  localparam logic [7:0] SFC_OFS_BOOTE = 8'h08;
  localparam logic [7:0] SFC_OFS_LOCK  = 8'h0A;
  localparam logic [7:0] SFC_SYS0_RST  = 8'hC4;
  localparam logic [7:0] SFC_SYS0_MASK = 8'hCD;
  localparam logic [7:0] SFC_SYS1_MASK = 8'h07;
  localparam logic [7:0] SFC_OPEN_CODE = 8'hC5;
  // Field positions.
  localparam int SFC_CRC_LSB = 6;
  localparam int SFC_PIN_LSB = 2;
  localparam int SFC_KEEP_BIT = 0;
  // Scan regions and pin functions.
  localparam logic [1:0] SFC_CRC_FULL = 2'h0;
  localparam logic [1:0] SFC_CRC_BOOT = 2'h1;
  localparam logic [1:0] SFC_CRC_BAPP = 2'h2;
  localparam logic [1:0] SFC_CRC_NONE = 2'h3;
  localparam logic [1:0] SFC_PIN_GPIO = 2'h0;
  localparam logic [1:0] SFC_PIN_DBG  = 2'h1;
  localparam logic [1:0] SFC_PIN_RST  = 2'h2;
  // Flash access classes.
  localparam logic [1:0] SFC_CLS_BOOT = 2'h0;
  localparam logic [1:0] SFC_CLS_CODE = 2'h1;
  localparam logic [1:0] SFC_CLS_DATA = 2'h2;
  // Timing.
  localparam int SFC_CLK_PERIOD_NS = 100;
  localparam int SFC_STEP_TIME_NS  = 1000000;
  localparam int SFC_STEP_CYCLES   = SFC_STEP_TIME_NS / SFC_CLK_PERIOD_NS;
  localparam logic [9:0] SFC_PIN_HOLD_TICKS = 10'd768;
  typedef enum logic [1:0] {
    SFC_ST_LOAD  = 2'b00,
    SFC_ST_DELAY = 2'b01,
    SFC_ST_RUN   = 2'b11
  } sfc_state_t;
endpackage

// ---- src/sfc_fuse_decode.sv ----
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module sfc_fuse_decode
  import sfc_pkg::*;
#(
  parameter int STEP_CYCLES = SFC_STEP_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  fuse_sys0,
  input  wire logic [7:0]  fuse_sys1,
  input  wire logic [7:0]  fuse_app_end,
  input  wire logic [7:0]  fuse_boot_end,
  input  wire logic [7:0]  fuse_lock,
  input  wire logic        slow_tick,
  input  wire logic [15:0] flash_addr,
  input  wire logic        dbg_req,
  input  wire logic        dbg_cs_space,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic [1:0]       crc_scan_source,
  output logic [1:0]       reset_pin_function,
  output logic             gpio_drive_ok,
  output logic             eeprom_erase_on_chip_erase,
  output logic             device_locked,
  output logic             dbg_grant,
  output logic             code_run,
  output logic [1:0]       flash_class
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire rst_n_s = rst_s2_q;

  // ----------------------------------------
  // Fuse holding registers
  // ----------------------------------------
  sfc_state_t state_q;
  sfc_state_t state_d;
  logic [7:0] sys0_q;
  logic [7:0] sys1_q;
  logic [7:0] app_end_q;
  logic [7:0] boot_end_q;
  logic [7:0] lock_q;

  wire is_load  = (state_q == SFC_ST_LOAD);
  wire lock_wr  = reg_wr && (reg_addr == SFC_OFS_LOCK) && !is_load;

  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sys0_q     <= SFC_SYS0_RST;
      sys1_q     <= 8'h00;
      app_end_q  <= 8'h00;
      boot_end_q <= 8'h00;
      lock_q     <= 8'h00;
    end else if (is_load) begin
      // Captured once; all but lock_q then frozen until the next reset, lock_q stays writable.
      sys0_q     <= fuse_sys0 & SFC_SYS0_MASK;
      sys1_q     <= fuse_sys1 & SFC_SYS1_MASK;
      app_end_q  <= fuse_app_end;
      boot_end_q <= fuse_boot_end;
      lock_q     <= fuse_lock;
    end else if (lock_wr) begin
      lock_q     <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire [1:0] crc_fld  = sys0_q[SFC_CRC_LSB+1:SFC_CRC_LSB];
  wire [1:0] pin_fld  = sys0_q[SFC_PIN_LSB+1:SFC_PIN_LSB];
  wire       keep_ee  = sys0_q[SFC_KEEP_BIT];
  wire       locked_w = (lock_q != SFC_OPEN_CODE);
  wire       erase_ee = locked_w || !keep_ee;
  wire       pin_gpio = (pin_fld == SFC_PIN_GPIO);
  wire       grant_w  = dbg_req && (!locked_w || dbg_cs_space);

  // ----------------------------------------
  // Flash classification
  // ----------------------------------------
  wire [7:0] blk      = flash_addr[15:8];
  wire       in_boot  = (boot_end_q == 8'h00) || (blk < boot_end_q);
  wire       in_code  = (app_end_q == 8'h00) || (blk < app_end_q);
  wire [1:0] class_w  = in_boot ? SFC_CLS_BOOT :
                        in_code ? SFC_CLS_CODE : SFC_CLS_DATA;

  // ----------------------------------------
  // Pin driver hold after reset
  // ----------------------------------------
  logic [9:0] hold_cnt_q;
  logic       hold_done_q;

  wire hold_last = slow_tick && (hold_cnt_q == SFC_PIN_HOLD_TICKS - 10'd1);

  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      hold_cnt_q  <= 10'h000;
      hold_done_q <= 1'b0;
    end else if (!hold_done_q && slow_tick) begin
      hold_cnt_q  <= hold_cnt_q + 10'd1;
      hold_done_q <= hold_last;
    end
  end

  // ----------------------------------------
  // Start-up delay
  // ----------------------------------------
  logic [19:0] cyc_cnt_q;
  logic [6:0]  step_cnt_q;

  wire [2:0] startup_delay_select      = sys1_q[2:0];
  wire [6:0] step_tgt = (startup_delay_select == 3'h0) ? 7'h00 : 7'(7'h01 << (startup_delay_select - 3'h1));
  wire       step_end = (cyc_cnt_q == 20'(STEP_CYCLES - 1));
  wire       dly_done = (step_cnt_q == step_tgt);

  always_comb begin
    case (state_q)
      SFC_ST_LOAD:  state_d = SFC_ST_DELAY;
      SFC_ST_DELAY: state_d = dly_done ? SFC_ST_RUN : SFC_ST_DELAY;
      SFC_ST_RUN:   state_d = SFC_ST_RUN;
      default:      state_d = SFC_ST_LOAD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_q <= SFC_ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cyc_cnt_q  <= 20'h00000;
      step_cnt_q <= 7'h00;
    end else if (state_q == SFC_ST_DELAY && !dly_done) begin
      cyc_cnt_q  <= step_end ? 20'h00000 : cyc_cnt_q + 20'h00001;
      step_cnt_q <= step_end ? step_cnt_q + 7'h01 : step_cnt_q;
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    case (reg_addr)
      SFC_OFS_SYS0:  rd_mux = sys0_q;
      SFC_OFS_SYS1:  rd_mux = sys1_q;
      SFC_OFS_APPE:  rd_mux = app_end_q;
      SFC_OFS_BOOTE: rd_mux = boot_end_q;
      SFC_OFS_LOCK:  rd_mux = lock_q;
      default:       rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      reg_rdata                  <= 8'h00;
      crc_scan_source            <= SFC_CRC_NONE;
      reset_pin_function         <= SFC_PIN_RST;
      gpio_drive_ok              <= 1'b0;
      eeprom_erase_on_chip_erase <= 1'b1;
      device_locked              <= 1'b1;
      dbg_grant                  <= 1'b0;
      code_run                   <= 1'b0;
      flash_class                <= SFC_CLS_BOOT;
    end else begin
      reg_rdata                  <= reg_rd ? rd_mux : 8'h00;
      crc_scan_source            <= crc_fld;
      reset_pin_function         <= pin_fld;
      gpio_drive_ok              <= pin_gpio && hold_done_q;
      eeprom_erase_on_chip_erase <= erase_ee;
      device_locked              <= locked_w;
      dbg_grant                  <= grant_w;
      code_run                   <= (state_q == SFC_ST_RUN);
      flash_class                <= class_w;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_s);

  logic past_ok_q;

  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      past_ok_q <= 1'b0;
    end else begin
      past_ok_q <= 1'b1;
    end
  end

  chk_crc_region_map: assert property (
    past_ok_q |-> crc_scan_source == $past(sys0_q[7:6]))
    else $error("Scan source output does not follow its field.");

  chk_pin_func_map: assert property (
    past_ok_q |-> reset_pin_function == $past(sys0_q[3:2]))
    else $error("Pin function output does not follow its field.");

  chk_gpio_hold_time: assert property (
    gpio_drive_ok |-> hold_cnt_q == SFC_PIN_HOLD_TICKS)
    else $error("Pin driver enabled before the hold period ended.");

  chk_ee_keep_open: assert property (
    (past_ok_q && $past(lock_q) == SFC_OPEN_CODE)
      |-> eeprom_erase_on_chip_erase == !$past(sys0_q[0]))
    else $error("Open device ignores the EEPROM keep bit.");

  chk_ee_lock_erase: assert property (
    (past_ok_q && $past(lock_q) != SFC_OPEN_CODE) |-> eeprom_erase_on_chip_erase)
    else $error("Locked device kept the EEPROM.");

  chk_startup_zero: assert property (
    (state_q == SFC_ST_DELAY && startup_delay_select == 3'h0) |=> state_q == SFC_ST_RUN)
    else $error("Zero start-up delay did not run at once.");

  chk_startup_steps: assert property (
    (state_q == SFC_ST_RUN) |-> step_cnt_q == step_tgt)
    else $error("Start-up delay ended after the wrong step count.");

  chk_class_data: assert property (
    flash_class == SFC_CLS_DATA
      |-> $past(app_end_q) != 8'h00 && $past(blk) >= $past(app_end_q))
    else $error("Data class given below the application end.");

  chk_class_boot: assert property (
    (past_ok_q && $past(boot_end_q) == 8'h00) |-> flash_class == SFC_CLS_BOOT)
    else $error("Zero boot end did not give boot class.");

  chk_lock_open: assert property (
    past_ok_q |-> device_locked == ($past(lock_q) != SFC_OPEN_CODE))
    else $error("Lock state does not match the lock code.");

  chk_dbg_denied: assert property (
    (device_locked && dbg_req && !dbg_cs_space && lock_q == $past(lock_q))
      |=> !dbg_grant)
    else $error("Locked device granted system bus access.");

  chk_fuse_frozen: assert property (
    (!is_load && !$past(is_load) && past_ok_q) |-> $stable(sys0_q) && $stable(app_end_q))
    else $error("Fuse copy changed after loading.");

  chk_rdata_idle: assert property (
    (past_ok_q && !$past(reg_rd)) |-> reg_rdata == 8'h00)
    else $error("Read data shown without a read strobe.");

  chk_rdata_lock: assert property (
    (past_ok_q && $past(reg_rd) && $past(reg_addr) == SFC_OFS_LOCK) |-> reg_rdata == $past(lock_q))
    else $error("Lock code read back wrong.");

  chk_gpio_mode_only: assert property (
    gpio_drive_ok |-> reset_pin_function == SFC_PIN_GPIO)
    else $error("Pin driver enabled outside general-purpose mode.");

  chk_dbg_cs_open: assert property (
    (past_ok_q && $past(dbg_req) && $past(dbg_cs_space)) |-> dbg_grant)
    else $error("Control space request was not granted.");

  cov_run_reached: cover property (state_q == SFC_ST_DELAY ##1 state_q == SFC_ST_RUN);
  cov_gpio_release: cover property (!gpio_drive_ok ##1 gpio_drive_ok);
  cov_dbg_blocked: cover property (device_locked && dbg_req && !dbg_cs_space);
  cov_class_code: cover property (flash_class == SFC_CLS_CODE);

endmodule // sfc_fuse_decode

// ---- tb/system_fuse_config_decode_tb.sv ----
`timescale 1ns/1ps
module system_fuse_config_decode_tb;
  import sfc_pkg::*;
  localparam int STEP = 4;
  logic        clk_sys, rst_b, slow_tick, dbg_req, dbg_cs_space, reg_wr, reg_rd;
  logic [7:0]  fuse_sys0, fuse_sys1, fuse_app_end, fuse_boot_end, fuse_lock;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [15:0] flash_addr;
  logic [1:0]  crc_scan_source, reset_pin_function, flash_class;
  logic        gpio_drive_ok, eeprom_erase_on_chip_erase, device_locked, dbg_grant, code_run;
  int          bad_count, tests_run, seed, ticks, base;

  sfc_fuse_decode #(.STEP_CYCLES(STEP)) i_sfc_fuse_decode (
    .clk_sys(clk_sys), .rst_b(rst_b), .fuse_sys0(fuse_sys0), .fuse_sys1(fuse_sys1),
    .fuse_app_end(fuse_app_end), .fuse_boot_end(fuse_boot_end), .fuse_lock(fuse_lock),
    .slow_tick(slow_tick), .flash_addr(flash_addr), .dbg_req(dbg_req),
    .dbg_cs_space(dbg_cs_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .crc_scan_source(crc_scan_source), .reset_pin_function(reset_pin_function),
    .gpio_drive_ok(gpio_drive_ok), .eeprom_erase_on_chip_erase(eeprom_erase_on_chip_erase),
    .device_locked(device_locked), .dbg_grant(dbg_grant), .code_run(code_run),
    .flash_class(flash_class));

  // ----------------------------------------
  // Clock, slow oscillator ticks, watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    slow_tick <= ~slow_tick;
    if (!rst_b) ticks <= 0;
    else if (slow_tick) ticks <= ticks + 1;
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    end_of_test();
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  task automatic wait_ticks(input int n);
    while (ticks < n) @(posedge clk_sys);
    #1;
  endtask

  function automatic int classify(input int blk, input int a, input int b);
    if (b == 0 || blk < b) return 0;
    if (a == 0 || blk < a) return 1;
    return 2;
  endfunction

  // ----------------------------------------
  // One reset with one fuse set
  // ----------------------------------------
  task automatic run_one(input int i);
    logic [7:0] s0, s1, a, b, l;
    logic       lk;
    logic [15:0] fa;
    int cyc, dly, cls;
    s0 = 8'($random(seed));
    s0[7:6] = i[1:0];
    s0[3:2] = i[1:0];
    s1 = 8'($random(seed));
    s1[2:0] = i[2:0];
    b = (i == 0) ? 8'h00 : 8'($random(seed));
    // Application end is zero in the first two runs and otherwise never set below the boot end, as a programmer would set it.
    a = (i < 2) ? 8'h00 : (b | 8'($random(seed)));
    l = i[0] ? SFC_OPEN_CODE : 8'($random(seed));
    lk = (l != SFC_OPEN_CODE);
    @(posedge clk_sys);
    rst_b <= 1'b0; fuse_sys0 <= s0; fuse_sys1 <= s1;
    fuse_app_end <= a; fuse_boot_end <= b; fuse_lock <= l;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc = 0;
    while (code_run !== 1'b1 && cyc < 400) begin
      @(posedge clk_sys); #1 cyc++;
    end
    if (i == 0) base = cyc;
    dly = (s1[2:0] == 0) ? 0 : (1 << (s1[2:0] - 1)) * STEP;
    chk(16'(cyc - base), 16'(dly));
    chk({14'h0, crc_scan_source}, {14'h0, s0[7:6]});
    chk({14'h0, reset_pin_function}, {14'h0, s0[3:2]});
    chk({15'h0, device_locked}, {15'h0, lk});
    chk({15'h0, eeprom_erase_on_chip_erase}, {15'h0, lk || !s0[0]});
    rd_chk(SFC_OFS_SYS0, s0 & SFC_SYS0_MASK);
    rd_chk(SFC_OFS_SYS1, s1 & SFC_SYS1_MASK);
    rd_chk(SFC_OFS_APPE, a);
    rd_chk(SFC_OFS_BOOTE, b);
    rd_chk(SFC_OFS_LOCK, l);
    rd_chk(8'h09, 8'h00);
    wr(SFC_OFS_SYS0, ~s0);
    rd_chk(SFC_OFS_SYS0, s0 & SFC_SYS0_MASK);
    repeat (8) begin
      fa = 16'($random(seed));
      cls = classify(fa[15:8], a, b);
      @(posedge clk_sys);
      flash_addr <= fa;
      dbg_req <= 1'($random(seed));
      dbg_cs_space <= 1'($random(seed));
      @(posedge clk_sys);
      #1 chk({14'h0, flash_class}, 16'(cls));
      chk({15'h0, dbg_grant}, {15'h0, dbg_req && (!lk || dbg_cs_space)});
    end
    wr(SFC_OFS_LOCK, SFC_OPEN_CODE);
    repeat (2) @(posedge clk_sys);
    #1 chk({15'h0, device_locked}, 16'h0000);
    chk({15'h0, eeprom_erase_on_chip_erase}, {15'h0, !s0[0]});
    wr(SFC_OFS_LOCK, 8'h3A);
    repeat (2) @(posedge clk_sys);
    #1 chk({15'h0, device_locked}, 16'h0001);
    chk({15'h0, eeprom_erase_on_chip_erase}, 16'h0001);
    rd_chk(SFC_OFS_LOCK, 8'h3A);
    // The pin driver stays off until the hold count is through, then follows the mode.
    wait_ticks(760);
    chk({15'h0, gpio_drive_ok}, 16'h0000);
    // Once the hold period is over, the pin driver enable follows the pin mode.
    wait_ticks(790);
    chk({15'h0, gpio_drive_ok}, {15'h0, s0[3:2] == SFC_PIN_GPIO});
    $display("test %0d done", i);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h7aa4;
    rst_b = 1'b0; slow_tick = 1'b0; dbg_req = 1'b0; dbg_cs_space = 1'b0;
    reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    flash_addr = 16'h0000; fuse_sys0 = 8'h00; fuse_sys1 = 8'h00;
    fuse_app_end = 8'h00; fuse_boot_end = 8'h00; fuse_lock = 8'h00;
    bad_count = 0; tests_run = 0; base = 0;
    repeat (6) @(posedge clk_sys);
    #1 chk({15'h0, device_locked}, 16'h0001);
    chk({15'h0, gpio_drive_ok}, 16'h0000);
    chk({15'h0, code_run}, 16'h0000);
    for (int i = 0; i < 8; i++) run_one(i);
    end_of_test();
  end
endmodule // system_fuse_config_decode_tb
